// [logic/chw_halt_ctrl.sv]
`timescale 1ns/10ps
`include "chw_consts.svh"

module chw_halt_ctrl
	import chw_pkg::*;
#(
	parameter int NKEY = 4,
	parameter int NINT = 6
) (
	input  wire logic            clk_sys,         // system clock, 200 MHz
	input  wire logic            rst,             // power-on reset, async, active high
	input  wire logic            ce_pin,          // enable/reset pin, asynchronous
	input  wire logic [NKEY-1:0] key_return_pins, // key return pin levels, asynchronous
	input  wire logic            halt_exec,       // decoder pulse: halt instruction
	input  wire chw_nib_t        halt_operand,    // operand of the halt instruction
	input  wire logic            btm0_carry,      // timer-0 carry flag level
	input  wire logic [NINT-1:0] int_req,         // interrupt requests per source
	input  wire logic [NINT-1:0] int_en,          // per-source interrupt enables
	input  wire logic            int_gie,         // global interrupt enable
	input  wire logic            key_phase,       // display scan in key source phase
	input  wire logic            adc_sel_en,      // a key pin feeds the converter
	input  wire logic [1:0]      adc_sel,         // which key pin feeds the converter
	input  wire logic            reg_wr,          // register write strobe
	input  wire logic            reg_rd,          // register read strobe
	input  wire logic [7:0]      reg_addr,        // register address
	input  wire chw_nib_t        reg_wdata,       // register write data
	output chw_nib_t             reg_rdata_r,     // register read data
	output logic                 cpu_clk_en_r,    // cpu clock gate enable
	output logic                 periph_clk_en_r, // peripheral clock enable
	output logic                 halted_r,        // cpu is halted
	output logic                 resume_next_r,   // pulse: continue after halt
	output logic                 int_wake_r,      // pulse: release came from interrupt
	output logic                 reset_seq_r,     // pulse: run reset sequence
	output logic [NKEY-1:0]      key_pulldown_r,  // pull-down enables per key pin
	output logic [NKEY-1:0]      adc_route_r,     // one-hot pin routed to converter
	output logic [NKEY-1:0]      key_latch_r      // latched key levels
);

	chw_state_e      state_r;
	chw_state_e      state_nxt;
	chw_nib_t        armed_r;
	chw_nib_t        display_mode_select_r;
	chw_nib_t        key_source_pattern_r;
	logic [NKEY:0]   pins_sync;
	logic            ce_sync;
	logic            ce_d_r;
	logic            ce_rise;
	logic            por_done_r;
	logic            key_scan_mux_flag;
	logic [NKEY-1:0] key_latch;
	logic [NKEY-1:0] pulldown_en;
	logic [NKEY-1:0] adc_route_nxt;
	logic            wake_key;
	logic            wake_tmr;
	logic            wake_int;
	logic            int_accept;
	logic            wake_any;
	logic            halting;

	// enable pin and key pins cross into the clock domain together
	chw_sync2 #(
		.W (NKEY + 1)
	) u_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in ({ce_pin, key_return_pins}),
		.sync_out (pins_sync)
	);

	assign ce_sync = pins_sync[NKEY];

	// edge detector on the synchronised enable level
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ce_d_r <= 1'b0;
		end else begin
			ce_d_r <= ce_sync;
		end
	end

	assign ce_rise = ce_sync && !ce_d_r;

	assign key_scan_mux_flag = display_mode_select_r[`CHW_KEY_SCAN_MUX_FLAG_BIT];

	always_comb begin
		adc_route_nxt = `CHW_ROUTE_RST;
		if (adc_sel_en) begin
			adc_route_nxt[adc_sel] = 1'b1;
		end
	end

	// converter routing register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			adc_route_r <= `CHW_ROUTE_RST;
		end else begin
			adc_route_r <= adc_route_nxt;
		end
	end

	// key latch and pull-down front end
	chw_key_front #(
		.N (NKEY)
	) u_key (
		.clk_sys     (clk_sys),
		.rst         (rst),
		.pin_sync    (pins_sync[NKEY-1:0]),
		.mux_mode    (key_scan_mux_flag),
		.key_phase   (key_phase),
		.src_nonzero (key_source_pattern_r != `CHW_NIB_ZERO),
		.adc_route   (adc_route_r),
		.key_latch   (key_latch),
		.pulldown_en (pulldown_en)
	);

	// pull-down drive registered to the pins
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			key_pulldown_r <= '1;
			key_latch_r    <= '0;
		end else begin
			key_pulldown_r <= pulldown_en;
			key_latch_r    <= key_latch;
		end
	end

	// register writes; reset values restored by either reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			display_mode_select_r <= `CHW_DISP_MODE_RST;
			key_source_pattern_r  <= `CHW_KEY_SRC_RST;
		end else if (ce_rise) begin
			display_mode_select_r <= `CHW_DISP_MODE_RST;
			key_source_pattern_r  <= `CHW_KEY_SRC_RST;
		end else if (reg_wr) begin
			if (reg_addr == `CHW_ADDR_DISP_MODE) begin
				display_mode_select_r <= reg_wdata;
			end
			if (reg_addr == `CHW_ADDR_KEY_SRC) begin
				key_source_pattern_r <= reg_wdata;
			end
		end
	end

	// register reads; unmapped addresses read zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata_r <= `CHW_NIB_ZERO;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`CHW_ADDR_DISP_MODE: begin
					reg_rdata_r <= display_mode_select_r;
				end
				`CHW_ADDR_KEY_SRC: begin
					reg_rdata_r <= key_source_pattern_r;
				end
				default: begin
					reg_rdata_r <= `CHW_NIB_ZERO;
				end
			endcase
		end
	end

	// interrupt accepted only with global and source enable
	assign int_accept = int_gie && |(int_req & int_en);

	// key wake, any latched high return level
	assign wake_key = armed_r[`CHW_OP_KEY_BIT] && |key_latch;
	assign wake_tmr = armed_r[`CHW_OP_TMR_BIT] && btm0_carry;
	assign wake_int = armed_r[`CHW_OP_INT_BIT] && int_accept;
	// wake conditions ORed; nothing armed never wakes
	assign wake_any = wake_key || wake_tmr || wake_int;

	// halt taken regardless of the enable pin level
	assign halting = halt_exec && (state_r == CHW_ST_RUN);

	// next state sampled every cycle during halt
	always_comb begin
		state_nxt = state_r;
		if (ce_rise) begin
			state_nxt = CHW_ST_RUN;
		end else begin
			unique case (state_r)
				CHW_ST_RUN: begin
					if (halting) begin
						state_nxt = CHW_ST_HALT;
					end
				end
				CHW_ST_HALT: begin
					if (wake_any) begin
						state_nxt = CHW_ST_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r <= CHW_ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// operand captured; undefined bit cannot arm anything
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			armed_r <= `CHW_ARMED_RST;
		end else if (ce_rise) begin
			armed_r <= `CHW_ARMED_RST;
		end else if (halting) begin
			armed_r <= halt_operand & `CHW_OP_DEFINED_MASK;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cpu_clk_en_r <= 1'b1;
			halted_r     <= 1'b0;
		end else begin
			cpu_clk_en_r <= (state_nxt == CHW_ST_RUN);
			halted_r     <= (state_nxt == CHW_ST_HALT);
		end
	end

	// peripheral clock never touched by halt
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			periph_clk_en_r <= 1'b1;
		end else begin
			periph_clk_en_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			resume_next_r <= 1'b0;
			int_wake_r    <= 1'b0;
		end else begin
			resume_next_r <= (state_r == CHW_ST_HALT) && wake_any && !ce_rise;
			int_wake_r    <= (state_r == CHW_ST_HALT) && wake_int && !ce_rise;
		end
	end

	// reset sequence once after power-on and on every pin reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			por_done_r  <= 1'b0;
			reset_seq_r <= 1'b0;
		end else begin
			por_done_r  <= 1'b1;
			reset_seq_r <= ce_rise || !por_done_r;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking

	default disable iff (rst);

	// halt entry and armed release steps
	sequence s_halt_entry;
		halting && !ce_rise;
	endsequence

	sequence s_release;
		(state_r == CHW_ST_HALT) && wake_any && !ce_rise;
	endsequence

	sequence s_resumed;
		!halted_r && cpu_clk_en_r && resume_next_r;
	endsequence

	a_halt_gates_clock: assert property (
		halted_r |-> !cpu_clk_en_r && (state_r == CHW_ST_HALT))
		else $error("cpu clock running while halted");

	a_halt_any_ce: assert property (
		s_halt_entry |=> halted_r && !cpu_clk_en_r)
		else $error("halt instruction not honoured");

	a_periph_kept: assert property (
		halted_r |-> periph_clk_en_r)
		else $error("peripheral clock stopped during halt");

	a_unarmed_holds: assert property (
		halted_r && ((armed_r & `CHW_OP_DEFINED_MASK) == `CHW_NIB_ZERO) && !ce_rise
		|=> halted_r)
		else $error("halt left with nothing armed");

	a_release_resumes: assert property (
		s_release |=> s_resumed)
		else $error("armed wake did not resume execution");

	a_ce_ends_halt: assert property (
		ce_rise |=> !halted_r && reset_seq_r && (armed_r == `CHW_ARMED_RST))
		else $error("pin reset did not end halt");

	a_key_wake: assert property (
		halted_r && armed_r[`CHW_OP_KEY_BIT] && |key_latch && !ce_rise
		|=> resume_next_r && (int_wake_r == $past(wake_int)))
		else $error("key level did not release halt");

	a_timer_wake: assert property (
		halted_r && (armed_r == 4'h2) && btm0_carry && !ce_rise |=> resume_next_r)
		else $error("timer carry did not release halt");

	a_int_enable: assert property (
		int_wake_r |-> $past(int_gie) && $past(armed_r[`CHW_OP_INT_BIT]))
		else $error("interrupt release without enables");

	a_rsvd_unarmed: assert property (
		!armed_r[`CHW_OP_RSVD_BIT])
		else $error("undefined operand bit armed");

	a_direct_pulldown: assert property (
		!$past(key_scan_mux_flag) |-> (key_pulldown_r == '1))
		else $error("pull-downs off in direct key mode");

	a_adc_one_pin: assert property (
		$onehot0(adc_route_r))
		else $error("more than one pin routed to converter");

	a_entry_release: assert property (
		s_halt_entry ##1 s_release |=> !halted_r)
		else $error("true condition at entry did not release next cycle");

endmodule : chw_halt_ctrl

// [logic/chw_consts.svh]
`ifndef CHW_CONSTS_SVH
`define CHW_CONSTS_SVH

// register addresses as seen on the register port
`define CHW_ADDR_DISP_MODE  8'h10
`define CHW_ADDR_KEY_SRC    8'h42

// field positions
`define CHW_KEY_SCAN_MUX_FLAG_BIT        0
`define CHW_OP_KEY_BIT      0
`define CHW_OP_TMR_BIT      1
`define CHW_OP_RSVD_BIT     2
`define CHW_OP_INT_BIT      3

// operand bits that carry a wake function
`define CHW_OP_DEFINED_MASK 4'hB

// reset values
`define CHW_DISP_MODE_RST   4'h0
`define CHW_KEY_SRC_RST     4'h0
`define CHW_ARMED_RST       4'h0
`define CHW_NIB_ZERO        4'h0
`define CHW_ROUTE_RST       4'h0

`endif

// [logic/chw_pkg.sv]
package chw_pkg;

	// cpu halt state
	typedef enum logic {
		CHW_ST_RUN,
		CHW_ST_HALT
	} chw_state_e;

	// one nibble of register or operand data
	typedef logic [3:0] chw_nib_t;

endpackage : chw_pkg

// [logic/chw_sync2.sv]
`timescale 1ns/10ps

module chw_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,  // system clock
	input  wire logic         rst,      // async reset, active high
	input  wire logic [W-1:0] async_in, // levels from outside the domain
	output logic      [W-1:0] sync_out  // synchronised levels
);

	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// two-stage synchroniser; only the second stage leaves the module
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;

endmodule : chw_sync2

// [logic/chw_key_front.sv]
`timescale 1ns/10ps

module chw_key_front #(
	parameter int N = 4
) (
	input  wire logic         clk_sys,     // system clock
	input  wire logic         rst,         // async reset, active high
	input  wire logic [N-1:0] pin_sync,    // synchronised key return levels
	input  wire logic         mux_mode,    // key source shared with segments
	input  wire logic         key_phase,   // key source phase of the display scan
	input  wire logic         src_nonzero, // key source pattern not all zero
	input  wire logic [N-1:0] adc_route,   // one-hot pin given to the converter
	output logic      [N-1:0] key_latch,   // latched key return levels
	output logic      [N-1:0] pulldown_en  // internal pull-down request
);

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_pin
			logic latch_r;
			logic capture;

			// converter pins hold; muxed pins sample in key phase only
			assign capture = !adc_route[i] && (!mux_mode || (key_phase && src_nonzero));

			// pull-downs always on in direct mode, key phase only when muxed
			assign pulldown_en[i] = mux_mode ? key_phase : 1'b1;

			// latch holds the last captured level, cleared for an empty pattern when muxed
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					latch_r <= 1'b0;
				end else if (capture) begin
					latch_r <= pin_sync[i];
				end else if (mux_mode && !src_nonzero && !adc_route[i]) begin
					latch_r <= 1'b0;
				end
			end

			assign key_latch[i] = latch_r;
		end
	endgenerate

endmodule : chw_key_front

// [tb/chw_key_model.sv]
`timescale 1ns/10ps

module chw_key_model #(
	parameter int N = 4
) (
	input  wire logic         clk_sys,        // system clock
	input  wire logic         rst,            // async reset, active high
	input  wire logic [N-1:0] sw_closed,      // key switch closed per return line
	input  wire logic [N-1:0] pulldown_en,    // pull-down request from the device
	output logic      [N-1:0] key_return_pins // resulting pin levels
);
	logic [N-1:0] float_r;

	// an open line with no pull-down wanders, so a latch never sees a stale level
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			float_r <= '0;
		end else begin
			float_r <= ~float_r;
		end
	end

	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (sw_closed[i]) begin
				key_return_pins[i] = 1'b1;
			end else begin
				key_return_pins[i] = pulldown_en[i] ? 1'b0 : float_r[i];
			end
		end
	end
endmodule : chw_key_model

// [tb/tb.sv]
`timescale 1ns/10ps
`include "chw_consts.svh"

module tb
	import chw_pkg::*;
;
	logic       clk_sys, rst, ce_pin, halt_exec, btm0_carry, int_gie, key_phase;
	logic       adc_sel_en, reg_wr, reg_rd, rel;
	logic       cpu_clk_en_r, periph_clk_en_r, halted_r, resume_next_r, int_wake_r;
	logic       reset_seq_r;
	logic [3:0] key_return_pins, sw_closed, key_pulldown_r, adc_route_r, key_latch_r;
	logic [5:0] int_req, int_en;
	logic [1:0] adc_sel;
	logic [7:0] reg_addr;
	chw_nib_t   halt_operand, reg_wdata, reg_rdata_r;
	int         n_errors = 0;
	int         total_checks = 0;
	int         cycles = 0;

	chw_halt_ctrl dut (.clk_sys(clk_sys), .rst(rst), .ce_pin(ce_pin),
		.key_return_pins(key_return_pins), .halt_exec(halt_exec),
		.halt_operand(halt_operand), .btm0_carry(btm0_carry), .int_req(int_req),
		.int_en(int_en), .int_gie(int_gie), .key_phase(key_phase),
		.adc_sel_en(adc_sel_en), .adc_sel(adc_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
		.cpu_clk_en_r(cpu_clk_en_r), .periph_clk_en_r(periph_clk_en_r),
		.halted_r(halted_r), .resume_next_r(resume_next_r), .int_wake_r(int_wake_r),
		.reset_seq_r(reset_seq_r), .key_pulldown_r(key_pulldown_r),
		.adc_route_r(adc_route_r), .key_latch_r(key_latch_r));

	chw_key_model keys (.clk_sys(clk_sys), .rst(rst), .sw_closed(sw_closed),
		.pulldown_en(key_pulldown_r), .key_return_pins(key_return_pins));

	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			n_errors++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input chw_nib_t d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		tick(1);
		reg_wr = 1'b0;
		tick(1);
	endtask : wr

	task automatic rd(input logic [7:0] a, input chw_nib_t exp);
		reg_addr = a;
		reg_rd = 1'b1;
		tick(1);
		reg_rd = 1'b0;
		tick(1);
		chk("reg_rdata", exp, reg_rdata_r);
	endtask : rd

	// one-cycle decoder pulse, then the halt must show at once
	task automatic halt(input chw_nib_t op);
		halt_operand = op;
		halt_exec = 1'b1;
		tick(1);
		halt_exec = 1'b0;
		chk("halted", 4'h1, {3'h0, halted_r});
		chk("cpu_clk_en", 4'h0, {3'h0, cpu_clk_en_r});
	endtask : halt

	// wait up to n cycles for release, then check the resume pulses
	task automatic rel_chk(input int n, input logic exp_rel, input logic exp_int);
		rel = 1'b0;
		for (int i = 0; i < n && !rel; i++) begin
			tick(1);
			rel = (halted_r === 1'b0);
		end
		chk("released", {3'h0, exp_rel}, {3'h0, rel});
		if (exp_rel) begin
			chk("resume_next", 4'h1, {3'h0, resume_next_r});
			chk("int_wake", {3'h0, exp_int}, {3'h0, int_wake_r});
			chk("cpu_clk_en", 4'h1, {3'h0, cpu_clk_en_r});
		end
	endtask : rel_chk

	// enable pin rising edge, bounded wait for the reset pulse
	task automatic pin_rst();
		ce_pin = 1'b1;
		for (int i = 0; i < 10 && reset_seq_r !== 1'b1; i++) begin
			tick(1);
		end
		chk("reset_seq", 4'h1, {3'h0, reset_seq_r});
		chk("halted", 4'h0, {3'h0, halted_r});
		ce_pin = 1'b0;
		tick(4);
	endtask : pin_rst

	task automatic endt(input string nm);
		$display("test %s done", nm);
	endtask : endt

	// 200 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// hang guard, far above the expected run length
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			$display("[ERR] run length expected 3000 seen more");
			complete_run();
		end
	end

	// main sequence
	initial begin
		{rst, ce_pin, halt_exec, btm0_carry, int_gie, key_phase} = 6'h20;
		{adc_sel_en, reg_wr, reg_rd, adc_sel, int_req, int_en} = '0;
		{sw_closed, reg_addr, reg_wdata, halt_operand} = '0;
		repeat (12) @(posedge clk_sys);
		#1 rst = 1'b0;
		chk("pulldown", 4'hF, key_pulldown_r);
		tick(1);
		chk("reset_seq", 4'h1, {3'h0, reset_seq_r});
		rd(`CHW_ADDR_DISP_MODE, 4'h0);
		wr(`CHW_ADDR_KEY_SRC, 4'hA);
		wr(8'h77, 4'h5);
		rd(`CHW_ADDR_KEY_SRC, 4'hA);
		rd(8'h77, 4'h0);
		endt("reset_regs");
		btm0_carry = 1'b1;
		{int_gie, int_en, int_req, sw_closed} = {1'b1, 6'h3F, 6'h3F, 4'hF};
		halt(4'h0);
		rel_chk(20, 1'b0, 1'b0);
		chk("periph_clk_en", 4'h1, {3'h0, periph_clk_en_r});
		pin_rst();
		rd(`CHW_ADDR_KEY_SRC, 4'h0);
		{btm0_carry, int_req, sw_closed} = '0;
		ce_pin = 1'b1;
		tick(4);
		endt("zero_operand");
		halt(4'h2);
		tick(3);
		btm0_carry = 1'b1;
		rel_chk(3, 1'b1, 1'b0);
		btm0_carry = 1'b0;
		ce_pin = 1'b0;
		int_req = 6'h3F;
		halt(4'h3);
		rel_chk(10, 1'b0, 1'b0);
		btm0_carry = 1'b1;
		rel_chk(3, 1'b1, 1'b0);
		halt(4'hB);
		rel_chk(1, 1'b1, 1'b1);
		btm0_carry = 1'b0;
		endt("timer");
		for (int i = 0; i < 6; i++) begin
			{int_gie, int_en, int_req} = {1'b0, 6'h01 << i, 6'h3F};
			halt(4'h8);
			tick(4);
			chk("halted", 4'h1, {3'h0, halted_r});
			{int_gie, int_req} = {1'b1, ~(6'h01 << i)};
			tick(4);
			chk("halted", 4'h1, {3'h0, halted_r});
			int_req = 6'h3F;
			rel_chk(3, 1'b1, 1'b1);
		end
		{int_gie, int_req} = '0;
		endt("interrupt");
		halt(4'h1);
		tick(3);
		sw_closed = 4'h8;
		rel_chk(6, 1'b1, 1'b0);
		sw_closed = 4'h0;
		tick(4);
		endt("key_direct");
		wr(`CHW_ADDR_DISP_MODE, 4'h1);
		wr(`CHW_ADDR_KEY_SRC, 4'h3);
		tick(2);
		chk("pulldown", 4'h0, key_pulldown_r);
		sw_closed = 4'h4;
		halt(4'h1);
		rel_chk(10, 1'b0, 1'b0);
		key_phase = 1'b1;
		rel_chk(6, 1'b1, 1'b0);
		chk("pulldown", 4'hF, key_pulldown_r);
		wr(`CHW_ADDR_KEY_SRC, 4'h0);
		tick(4);
		halt(4'h1);
		rel_chk(10, 1'b0, 1'b0);
		pin_rst();
		{sw_closed, key_phase} = '0;
		endt("key_mux");
		sw_closed = 4'h1;
		tick(4);
		adc_sel_en = 1'b1;
		tick(3);
		chk("adc_route", 4'h1, adc_route_r);
		sw_closed = 4'h0;
		tick(4);
		chk("key_latch", 4'h1, key_latch_r);
		halt(4'h1);
		rel_chk(2, 1'b1, 1'b0);
		adc_sel = 2'h2;
		tick(3);
		chk("adc_route", 4'h4, adc_route_r);
		adc_sel_en = 1'b0;
		tick(4);
		chk("key_latch", 4'h0, key_latch_r);
		endt("adc_pin");
		complete_run();
	end
endmodule : tb
